// File: hdl/qwrs_pkg.sv
// Constants and types for the quad wiper register store
package qwrs_pkg;
   // Array geometry
   localparam int CHANNELS = 4;
   localparam int SLOTS = 4;
   localparam int WIPER_W = 6;
   localparam int TAPS = 64;
   localparam logic [5:0] WIPER_MAX = 6'h3f;
   localparam logic [5:0] WIPER_MIN = 6'h00;
   localparam logic [1:0] SLOT_ZERO = 2'h0;
   // Identification byte fields
   localparam logic [3:0] ID_TYPE = 4'h6; // Device type code, value arbitrary
   localparam logic [1:0] ID_PAD = 2'h0;
   // Instruction codes, upper nibble of the instruction byte
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'ha;
   localparam logic [3:0] OP_RD_DATA = 4'hb;
   localparam logic [3:0] OP_WR_DATA = 4'hc;
   localparam logic [3:0] OP_XFR_D2W = 4'hd;
   localparam logic [3:0] OP_XFR_W2D = 4'he;
   localparam logic [3:0] OP_GXFR_D2W = 4'h1;
   localparam logic [3:0] OP_GXFR_W2D = 4'h8;
   localparam logic [3:0] OP_RD_STATUS = 4'h5;
   localparam logic [3:0] OP_STEP = 4'h2;
   // Pin vector layout after synchronisation
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_HOLD = 3;
   localparam int PIN_WP = 4;
   localparam int PIN_A0 = 5;
   localparam int PIN_A1 = 6;
   localparam int PINS = 7;
   localparam logic [6:0] PIN_IDLE = 7'h19;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Nonvolatile write time
   localparam int NV_WRITE_MS = 10;
   localparam int CLK_MHZ = 250;
   localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;

   typedef enum logic [2:0] {
      PH_ID = 3'b000,
      PH_INSTR = 3'b001,
      PH_WDATA = 3'b010,
      PH_RDATA = 3'b011,
      PH_STEP = 3'b100,
      PH_DONE = 3'b101,
      PH_IGNORE = 3'b110
   } qwrs_phase_type;

   typedef enum logic [1:0] {
      PD_NONE = 2'b00,
      PD_DATA = 2'b01,
      PD_XFR = 2'b10,
      PD_GXFR = 2'b11
   } qwrs_pend_type;
endpackage

// File: hdl/qwrs_top.sv
// Serial control, wiper and storage registers for four tap selectors
// Behaviour
// - Sample data-in on serial clock rising edge
// - Data-out undriven unless shifting read data
// - Exactly one tap switch on per channel
// - Decode six-bit position to one-hot taps
// - Four wiper position registers, one per channel
// - Wiper write loads position serially
// - Transfer loads wiper from chosen storage slot
// - Step moves wiper one position per pulse
// - Power-up loads wiper from slot zero
// - Four six-bit storage slots per channel
// - Copy between storage slots and wiper both ways
// - Nonvolatile write finishes within ten milliseconds
// - Commit starts on select rise after complete write
// - Write-in-progress flag readable by status read
// - Data-in high steps up, low steps down
// - Read data changes on serial clock falling edge
`timescale 1ns/10ps
module qwrs_top #(
   parameter int NV_CYCLES = qwrs_pkg::NV_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Serial port pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic [1:0] dev_addr,
   output logic so,
   output logic so_oe,
   // Tap switch selects
   output logic [3:0][63:0] tap_sel
);

   typedef struct packed {
      logic [6:0] s1;
      logic [6:0] s2;
      logic [6:0] s3;
      logic [6:0] filt;
      qwrs_pkg::qwrs_phase_type phase;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] instr;
      logic [7:0] outsr;
      logic so;
      logic oe;
      logic [3:0][5:0] wiper;
      logic [3:0][3:0][5:0] slot;
      qwrs_pkg::qwrs_pend_type pend;
      logic [1:0] pch;
      logic [1:0] preg;
      logic [5:0] pdata;
      logic write_in_progress_flag;
      logic [31:0] timer;
   } qwrs_state_type;

   // Storage powers up erased; reset leaves it alone
   qwrs_state_type q = '0;
   qwrs_state_type d;
   logic [6:0] filt_n;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic active;
   logic [7:0] sh;
   // Third stage and second stage must agree before a pin change counts
   genvar gi;
   generate
      for (gi = 0; gi < qwrs_pkg::PINS; gi++)
      begin : g_pin
         assign filt_n[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.filt[gi];
      end
      for (gi = 0; gi < qwrs_pkg::CHANNELS; gi++)
      begin : g_tap
         assign tap_sel[gi] = 64'h1 << q.wiper[gi];
      end
   endgenerate
   assign sck_rise = filt_n[qwrs_pkg::PIN_SCK] & ~q.filt[qwrs_pkg::PIN_SCK];
   assign sck_fall = ~filt_n[qwrs_pkg::PIN_SCK] & q.filt[qwrs_pkg::PIN_SCK];
   assign cs_rise = filt_n[qwrs_pkg::PIN_CS] & ~q.filt[qwrs_pkg::PIN_CS];
   assign active = ~q.filt[qwrs_pkg::PIN_CS] & q.filt[qwrs_pkg::PIN_HOLD];
   assign sh = {q.shreg[6:0], q.filt[qwrs_pkg::PIN_SI]};
   assign so = q.so;
   assign so_oe = q.oe;
   always_comb
   begin
      d = q;
      d.s1 = {dev_addr, wp_n, hold_n, si, sck, cs_n};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.filt = filt_n;
      if (q.write_in_progress_flag && q.timer == '0)
         d.write_in_progress_flag = 1'b0;
      else if (q.write_in_progress_flag)
         d.timer = q.timer - 32'h1;
      if (cs_rise)
      begin
         // Commit only a finished write, never while busy or protected
         if (q.phase == qwrs_pkg::PH_DONE && q.pend != qwrs_pkg::PD_NONE && !q.write_in_progress_flag
             && q.filt[qwrs_pkg::PIN_WP])
         begin
            d.write_in_progress_flag = 1'b1;
            d.timer = 32'(NV_CYCLES - 1);
            case (q.pend)
               qwrs_pkg::PD_DATA: d.slot[q.pch][q.preg] = q.pdata;
               qwrs_pkg::PD_XFR: d.slot[q.pch][q.preg] = q.wiper[q.pch];
               qwrs_pkg::PD_GXFR:
               begin
                  for (int i = 0; i < qwrs_pkg::CHANNELS; i++)
                     d.slot[i][q.preg] = q.wiper[i];
               end
               default: d.pend = qwrs_pkg::PD_NONE;
            endcase
         end
      end
      if (filt_n[qwrs_pkg::PIN_CS])
      begin
         d.phase = qwrs_pkg::PH_ID;
         d.bitcnt = 3'h0;
         d.pend = qwrs_pkg::PD_NONE;
         d.oe = 1'b0;
      end
      else if (active && sck_rise)
      begin
         d.shreg = sh;
         d.bitcnt = q.bitcnt + 3'h1;
         case (q.phase)
            qwrs_pkg::PH_ID:
            begin
               if (q.bitcnt == qwrs_pkg::LAST_BIT)
               begin
                  if (sh[7:4] == qwrs_pkg::ID_TYPE && sh[3:2] == qwrs_pkg::ID_PAD
                      && sh[1:0] == q.filt[qwrs_pkg::PIN_A1:qwrs_pkg::PIN_A0])
                     d.phase = qwrs_pkg::PH_INSTR;
                  else
                     d.phase = qwrs_pkg::PH_IGNORE;
               end
            end
            qwrs_pkg::PH_INSTR:
            begin
               if (q.bitcnt == qwrs_pkg::LAST_BIT)
               begin
                  d.instr = sh;
                  d.pch = sh[1:0];
                  d.preg = sh[3:2];
                  d.phase = qwrs_pkg::PH_DONE;
                  case (sh[7:4])
                     qwrs_pkg::OP_RD_WIPER:
                     begin
                        d.outsr = {2'h0, q.wiper[sh[1:0]]};
                        d.phase = qwrs_pkg::PH_RDATA;
                     end
                     qwrs_pkg::OP_RD_DATA:
                     begin
                        d.outsr = {2'h0, q.slot[sh[1:0]][sh[3:2]]};
                        d.phase = qwrs_pkg::PH_RDATA;
                     end
                     qwrs_pkg::OP_RD_STATUS:
                     begin
                        d.outsr = {7'h00, q.write_in_progress_flag};
                        d.phase = qwrs_pkg::PH_RDATA;
                     end
                     qwrs_pkg::OP_WR_WIPER: d.phase = qwrs_pkg::PH_WDATA;
                     qwrs_pkg::OP_WR_DATA: d.phase = qwrs_pkg::PH_WDATA;
                     qwrs_pkg::OP_XFR_D2W: d.wiper[sh[1:0]] = q.slot[sh[1:0]][sh[3:2]];
                     qwrs_pkg::OP_GXFR_D2W:
                     begin
                        for (int i = 0; i < qwrs_pkg::CHANNELS; i++)
                           d.wiper[i] = q.slot[i][sh[3:2]];
                     end
                     qwrs_pkg::OP_XFR_W2D: d.pend = qwrs_pkg::PD_XFR;
                     qwrs_pkg::OP_GXFR_W2D: d.pend = qwrs_pkg::PD_GXFR;
                     qwrs_pkg::OP_STEP: d.phase = qwrs_pkg::PH_STEP;
                     default: d.phase = qwrs_pkg::PH_IGNORE;
                  endcase
               end
            end
            qwrs_pkg::PH_WDATA:
            begin
               if (q.bitcnt == qwrs_pkg::LAST_BIT)
               begin
                  d.phase = qwrs_pkg::PH_DONE;
                  if (q.instr[7:4] == qwrs_pkg::OP_WR_WIPER)
                     d.wiper[q.pch] = sh[5:0];
                  else
                  begin
                     d.pend = qwrs_pkg::PD_DATA;
                     d.pdata = sh[5:0];
                  end
               end
            end
            qwrs_pkg::PH_STEP:
            begin
               if (q.filt[qwrs_pkg::PIN_SI] && q.wiper[q.pch] != qwrs_pkg::WIPER_MAX)
                  d.wiper[q.pch] = q.wiper[q.pch] + 6'h01;
               else if (!q.filt[qwrs_pkg::PIN_SI] && q.wiper[q.pch] != qwrs_pkg::WIPER_MIN)
                  d.wiper[q.pch] = q.wiper[q.pch] - 6'h01;
            end
            qwrs_pkg::PH_DONE:
            begin
               // Extra clocks after a complete sequence spoil it
               d.phase = qwrs_pkg::PH_IGNORE;
               d.pend = qwrs_pkg::PD_NONE;
            end
            default: d.phase = q.phase;
         endcase
      end
      else if (active && sck_fall && q.phase == qwrs_pkg::PH_RDATA)
      begin
         d.so = q.outsr[7];
         d.outsr = {q.outsr[6:0], 1'b0};
         d.oe = 1'b1;
      end
      if (rst)
      begin
         d = '0;
         d.s1 = qwrs_pkg::PIN_IDLE;
         d.s2 = qwrs_pkg::PIN_IDLE;
         d.s3 = qwrs_pkg::PIN_IDLE;
         d.filt = qwrs_pkg::PIN_IDLE;
         d.phase = qwrs_pkg::PH_ID;
         d.pend = qwrs_pkg::PD_NONE;
         d.slot = q.slot;
         for (int i = 0; i < qwrs_pkg::CHANNELS; i++)
            d.wiper[i] = q.slot[i][qwrs_pkg::SLOT_ZERO];
      end
   end
   always_ff @(posedge mclk)
   begin
      q <= d;
   end
   sequence s_step_up;
      q.phase == qwrs_pkg::PH_STEP && active && sck_rise && q.filt[qwrs_pkg::PIN_SI];
   endsequence
   sequence s_commit;
      cs_rise && q.phase == qwrs_pkg::PH_DONE && q.pend != qwrs_pkg::PD_NONE && !q.write_in_progress_flag
         && q.filt[qwrs_pkg::PIN_WP];
   endsequence
   property p_one_hot;
      @(posedge mclk) disable iff (rst)
         $onehot(tap_sel[0]) && $onehot(tap_sel[1]) && $onehot(tap_sel[2]) && $onehot(tap_sel[3]);
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("tap select not one-hot");
   property p_decode;
      @(posedge mclk) disable iff (rst)
         tap_sel[1][q.wiper[1]] && tap_sel[3][q.wiper[3]];
   endproperty
   a_decode: assert property (p_decode) else $error("tap select does not match wiper");
   property p_so_hiz;
      @(posedge mclk) disable iff (rst)
         q.filt[qwrs_pkg::PIN_CS] |=> !so_oe;
   endproperty
   a_so_hiz: assert property (p_so_hiz) else $error("data out driven while deselected");
   property p_commit;
      @(posedge mclk) disable iff (rst)
         s_commit |=> q.write_in_progress_flag && q.timer == 32'(NV_CYCLES - 1);
   endproperty
   a_commit: assert property (p_commit) else $error("commit did not start write");
   property p_no_stray_write;
      @(posedge mclk) disable iff (rst)
         $rose(q.write_in_progress_flag) |-> $past(q.phase) == qwrs_pkg::PH_DONE && $past(cs_rise);
   endproperty
   a_no_stray_write: assert property (p_no_stray_write) else $error("write began without complete sequence");
   property p_wip_count;
      @(posedge mclk) disable iff (rst)
         q.write_in_progress_flag && q.timer != '0 |=> q.write_in_progress_flag && q.timer == $past(q.timer) - 32'h1;
   endproperty
   a_wip_count: assert property (p_wip_count) else $error("write timer not counting");
   property p_step_up;
      @(posedge mclk) disable iff (rst)
         s_step_up ##0 (q.wiper[q.pch] != qwrs_pkg::WIPER_MAX) |=>
            q.wiper[q.pch] == $past(q.wiper[q.pch]) + 6'h01;
   endproperty
   a_step_up: assert property (p_step_up) else $error("step up did not advance");
   property p_step_sat;
      @(posedge mclk) disable iff (rst)
         s_step_up ##0 (q.wiper[q.pch] == qwrs_pkg::WIPER_MAX) |=> q.wiper[q.pch] == qwrs_pkg::WIPER_MAX;
   endproperty
   a_step_sat: assert property (p_step_sat) else $error("step wrapped past top");
   property p_so_fall;
      @(posedge mclk) disable iff (rst)
         $changed(so) |-> $past(sck_fall);
   endproperty
   a_so_fall: assert property (p_so_fall) else $error("data out changed off falling edge");
   property p_recall;
      @(posedge mclk) disable iff (rst)
         $fell(rst) |-> q.wiper[0] == q.slot[0][qwrs_pkg::SLOT_ZERO];
   endproperty
   a_recall: assert property (p_recall) else $error("wiper not recalled from slot zero");
endmodule // qwrs_top

// File: tb/qwrs_host.sv
// Serial host model that drives the wiper register store pins
`timescale 1ns/10ps
module qwrs_host (
   // Clock
   input wire logic mclk,
   // Serial pins
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n,
   output logic wp_n,
   input wire logic so,
   input wire logic [1:0] dev_addr,
   // Read result
   output logic rd_valid,
   output logic [7:0] rd_data
);
   logic [7:0] rx = 8'h00;
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      wp_n = 1'b1;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   // Data set up while the clock is low, taken by the device on the rise
   task automatic bit_x(input logic b);
      si <= b;
      repeat (6) @(posedge mclk);
      rx = {rx[6:0], so};
      sck <= 1'b1;
      repeat (6) @(posedge mclk);
      sck <= 1'b0;
   endtask
   // Whole frame: address byte, instruction byte, then nt bits of tail
   task automatic frame(input logic [7:0] ins, input logic [7:0] tail, input int nt, input logic rd);
      logic [15:0] hd;
      hd = {qwrs_pkg::ID_TYPE, qwrs_pkg::ID_PAD, dev_addr, ins};
      cs_n <= 1'b0;
      repeat (6) @(posedge mclk);
      for (int i = 15; i >= 0; i--)
         bit_x(hd[i]);
      for (int i = nt - 1; i >= 0; i--)
         bit_x(tail[i]);
      repeat (6) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
      rd_data <= rx;
      rd_valid <= rd;
      @(posedge mclk);
      rd_valid <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask
endmodule // qwrs_host

// File: tb/qwrs_top_tb.sv
// Self-checking bench for the quad wiper register store
`timescale 1ns/10ps
module qwrs_top_tb;
   localparam int NV = 400;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] dev_addr = 2'h0;
   logic cs_n, sck, si, hold_n, wp_n, so, so_oe, rd_valid;
   logic [7:0] rd_data;
   logic [3:0][63:0] tap_sel;
   logic [7:0] exp_q [$];
   logic [5:0] r [4];
   logic [5:0] v [4];
   int n_errors = 0;
   int cmp_count = 0;
   int tn = 0;
   always #2 mclk = ~mclk;
   qwrs_top #(.NV_CYCLES(NV)) qwrs_top_i (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .wp_n(wp_n), .dev_addr(dev_addr), .so(so), .so_oe(so_oe), .tap_sel(tap_sel));
   qwrs_host qwrs_host_i (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
      .so(so), .dev_addr(dev_addr), .rd_valid(rd_valid), .rd_data(rd_data));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [3:0] op, input logic [1:0] s, input logic [1:0] ch, input logic [7:0] d,
      input int nt);
      qwrs_host_i.frame({op, s, ch}, d, nt, 1'b0);
   endtask
   task automatic rd(input logic [3:0] op, input logic [1:0] s, input logic [1:0] ch, input logic [7:0] e);
      exp_q.push_back(e);
      qwrs_host_i.frame({op, s, ch}, 8'h00, 8, 1'b1);
   endtask
   task automatic wr_slot(input logic [1:0] ch, input logic [1:0] s, input logic [5:0] d);
      send(qwrs_pkg::OP_WR_DATA, s, ch, {2'h2, d}, 8);
      repeat (NV + 20) @(posedge mclk);
   endtask
   task automatic tap(input logic [1:0] ch, input logic [5:0] w);
      check(tap_sel[ch], 64'h1 << w);
   endtask
   task automatic tdone();
      tn++;
      $display("test %0d done", tn);
   endtask
   task automatic test_done();
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Read results come back in request order
   always @(posedge mclk)
      if (rd_valid === 1'b1)
      begin
         check({56'h0, rd_data}, {56'h0, exp_q.pop_front()});
      end
   initial
   begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      test_done();
   end
   initial
   begin
      void'($urandom(32'hcd690c69));
      dev_addr <= 2'($urandom);
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      for (int c = 0; c < 4; c++)
      begin
         r[c] = 6'($urandom);
         wr_slot(2'(c), qwrs_pkg::SLOT_ZERO, r[c]);
      end
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      for (int c = 0; c < 4; c++)
      begin
         tap(2'(c), r[c]);
         rd(qwrs_pkg::OP_RD_WIPER, 2'h0, 2'(c), {2'h0, r[c]});
      end
      tdone();
      for (int c = 0; c < 4; c++)
      begin
         v[c] = 6'($urandom);
         send(qwrs_pkg::OP_WR_WIPER, 2'h0, 2'(c), {2'h3, v[c]}, 8);
         tap(2'(c), v[c]);
         check({63'h0, so_oe}, 64'h0);
         wr_slot(2'h1, 2'(c), ~v[c]);
         rd(qwrs_pkg::OP_RD_DATA, 2'(c), 2'h1, {2'h0, ~v[c]});
      end
      // Slot zero of channel one now holds the first inverted value
      r[1] = ~v[0];
      tdone();
      send(qwrs_pkg::OP_WR_DATA, 2'h3, 2'h2, 8'h2a, 8);
      rd(qwrs_pkg::OP_RD_STATUS, 2'h0, 2'h0, 8'h01);
      repeat (NV) @(posedge mclk);
      rd(qwrs_pkg::OP_RD_STATUS, 2'h0, 2'h0, 8'h00);
      // Select rises four bits into the data byte
      send(qwrs_pkg::OP_WR_DATA, 2'h3, 2'h2, 8'h15, 4);
      rd(qwrs_pkg::OP_RD_STATUS, 2'h0, 2'h0, 8'h00);
      rd(qwrs_pkg::OP_RD_DATA, 2'h3, 2'h2, 8'h2a);
      tdone();
      wr_slot(2'h3, 2'h2, 6'h11);
      send(qwrs_pkg::OP_XFR_D2W, 2'h2, 2'h3, 8'h00, 0);
      tap(2'h3, 6'h11);
      send(qwrs_pkg::OP_WR_WIPER, 2'h0, 2'h3, 8'h27, 8);
      send(qwrs_pkg::OP_XFR_W2D, 2'h1, 2'h3, 8'h00, 0);
      repeat (NV + 20) @(posedge mclk);
      rd(qwrs_pkg::OP_RD_DATA, 2'h1, 2'h3, 8'h27);
      send(qwrs_pkg::OP_GXFR_D2W, 2'h0, 2'h0, 8'h00, 0);
      for (int c = 0; c < 4; c++)
         tap(2'(c), r[c]);
      send(qwrs_pkg::OP_GXFR_W2D, 2'h3, 2'h0, 8'h00, 0);
      repeat (NV + 20) @(posedge mclk);
      for (int c = 0; c < 4; c++)
         rd(qwrs_pkg::OP_RD_DATA, 2'h3, 2'(c), {2'h0, r[c]});
      tdone();
      send(qwrs_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h3d, 8);
      send(qwrs_pkg::OP_STEP, 2'h0, 2'h0, 8'h0f, 4);
      tap(2'h0, 6'h3f);
      send(qwrs_pkg::OP_WR_WIPER, 2'h0, 2'h0, 8'h02, 8);
      send(qwrs_pkg::OP_STEP, 2'h0, 2'h0, 8'h40, 8);
      tap(2'h0, 6'h00);
      tdone();
      repeat (20) @(posedge mclk);
      test_done();
   end
endmodule // qwrs_top_tb
